// ### stmcp_map.svh
`ifndef STMCP_MAP_SVH
`define STMCP_MAP_SVH
// Register byte addresses
`define STMCP_OFF_CTRL0  12'h000
`define STMCP_OFF_CTRL1  12'h004
`define STMCP_OFF_CNTL   12'h008
`define STMCP_OFF_CNTH   12'h00C
`define STMCP_OFF_CMPAL  12'h010
`define STMCP_OFF_CMPAH  12'h014
`define STMCP_OFF_FLAGS  12'h018
// Control zero fields
`define STMCP_C0_PAUSE   7
`define STMCP_C0_ON      3
// Control one fields
`define STMCP_C1_MODE    7:6
`define STMCP_C1_FUNC    5:4
`define STMCP_C1_INIT    3
`define STMCP_C1_INV     2
`define STMCP_C1_SWAP    1
`define STMCP_C1_CLRSEL  0
// Flag fields, write one to clear
`define STMCP_FL_A       0
`define STMCP_FL_P       1
// Default read byte and counter maximum
`define STMCP_RST_BYTE   8'h00
`define STMCP_CNT_MAX    10'h3FF
// Counter clock divider ratio
`define STMCP_DIV        4
`endif

// ### stmcp_pkg.sv
package stmcp_pkg;
  typedef enum logic [1:0] {
    STMCP_CMP = 2'h0, STMCP_CAP = 2'h1, STMCP_PWM = 2'h2, STMCP_TMR = 2'h3
  } stmcp_mode_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] func;
    logic       initLvl;
    logic       invert;
    logic       swap;
    logic       clrSel;
  } stmcp_ctrl1_t;
  typedef struct packed {
    logic       pause;
    logic       timerOn;
    logic [2:0] cmpP;
  } stmcp_ctrl0_t;
endpackage : stmcp_pkg

// ### stmcp_timer.sv
`timescale 1ns/100ps
`include "stmcp_map.svh"
module stmcp_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             timerOut,
  output logic             timerOutEn
);
  import stmcp_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  stmcp_ctrl0_t ctrl0_q;
  stmcp_ctrl1_t ctrl1_q;
  logic [9:0]   cmpA_q;
  logic [9:0]   cnt_q;
  logic         flagA_q;
  logic         flagP_q;
  logic         onPrev_q;
  logic         pin_q;
  logic [1:0]   div_q;
  logic         tick;
  logic         onRise;

  // Decode of a byte address into a register select, used by both paths
  function automatic logic isReg(input logic [11:0] a, input logic [11:0] off);
    isReg = (a == off);
  endfunction : isReg

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic [11:0] awAddr_q;
  logic        awHave_q;
  logic [31:0] wData_q;
  logic        wStrb0_q;
  logic        wHave_q;
  logic        wrFire;
  logic        wrOk;

  assign wrFire = awHave_q && wHave_q && !s_axi_bvalid;
  assign wrOk   = isReg(awAddr_q, `STMCP_OFF_CTRL0) || isReg(awAddr_q, `STMCP_OFF_CTRL1) ||
                  isReg(awAddr_q, `STMCP_OFF_CNTL)  || isReg(awAddr_q, `STMCP_OFF_CNTH)  ||
                  isReg(awAddr_q, `STMCP_OFF_CMPAL) || isReg(awAddr_q, `STMCP_OFF_CMPAH) ||
                  isReg(awAddr_q, `STMCP_OFF_FLAGS);

  // Address and data are latched independently, in either order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 12'h000;
      wData_q       <= 32'h0000_0000;
      wStrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !awHave_q && !s_axi_awready;
      s_axi_wready  <= !wHave_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q  <= 1'b1;
        wData_q  <= s_axi_wdata;
        wStrb0_q <= s_axi_wstrb[0];
      end
      if (wrFire) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? 2'h0 : 2'h2;      // SLVERR on unmapped address
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wrCtrl0, wrCtrl1, wrCmpL, wrCmpH, wrFlags;
  assign wrCtrl0 = wrFire && wStrb0_q && isReg(awAddr_q, `STMCP_OFF_CTRL0);
  assign wrCtrl1 = wrFire && wStrb0_q && isReg(awAddr_q, `STMCP_OFF_CTRL1);
  assign wrCmpL  = wrFire && wStrb0_q && isReg(awAddr_q, `STMCP_OFF_CMPAL);
  assign wrCmpH  = wrFire && wStrb0_q && isReg(awAddr_q, `STMCP_OFF_CMPAH);
  assign wrFlags = wrFire && wStrb0_q && isReg(awAddr_q, `STMCP_OFF_FLAGS);

  // Control and compare registers; counter registers ignore writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl0_q <= '0;
      ctrl1_q <= '0;
      cmpA_q  <= 10'h000;
    end else begin
      if (wrCtrl0) begin
        ctrl0_q.pause   <= wData_q[`STMCP_C0_PAUSE];
        ctrl0_q.timerOn <= wData_q[`STMCP_C0_ON];
        ctrl0_q.cmpP    <= wData_q[2:0];
      end
      if (wrCtrl1) ctrl1_q <= stmcp_ctrl1_t'(wData_q[7:0]);
      if (wrCmpL) cmpA_q[7:0] <= wData_q[7:0];
      if (wrCmpH) cmpA_q[9:8] <= wData_q[1:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0] rdByte;
  logic       rdOk;
  always_comb begin
    rdByte = `STMCP_RST_BYTE;
    rdOk   = 1'b1;
    if (isReg(s_axi_araddr, `STMCP_OFF_CTRL0))
      rdByte = {ctrl0_q.pause, 3'h0, ctrl0_q.timerOn, ctrl0_q.cmpP};
    else if (isReg(s_axi_araddr, `STMCP_OFF_CTRL1)) rdByte = ctrl1_q;
    else if (isReg(s_axi_araddr, `STMCP_OFF_CNTL))  rdByte = cnt_q[7:0];
    else if (isReg(s_axi_araddr, `STMCP_OFF_CNTH))  rdByte = {6'h00, cnt_q[9:8]};
    else if (isReg(s_axi_araddr, `STMCP_OFF_CMPAL)) rdByte = cmpA_q[7:0];
    else if (isReg(s_axi_araddr, `STMCP_OFF_CMPAH)) rdByte = {6'h00, cmpA_q[9:8]};
    else if (isReg(s_axi_araddr, `STMCP_OFF_FLAGS)) rdByte = {6'h00, flagP_q, flagA_q};
    else rdOk = 1'b0;
  end

  // One read at a time; address accepted and answered on the next edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                       (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rdByte};
        s_axi_rresp   <= rdOk ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter clock and counter
  // ----------------------------------------------------------------
  // Fixed divide gives the counter clock; source selection is not modelled
  always_ff @(posedge ref_clk) begin
    if (rst) div_q <= 2'h0;
    else div_q <= (div_q == 2'(`STMCP_DIV - 1)) ? 2'h0 : div_q + 2'h1;
  end
  assign tick   = (div_q == 2'h0);
  assign onRise = ctrl0_q.timerOn && !onPrev_q;

  logic isPwm, matchA, matchP, zeroA, clrCnt, setA, setP, perHit;
  logic [10:0] perCnt, dutyCnt;
  assign isPwm  = (ctrl1_q.mode == STMCP_PWM) && (ctrl1_q.func != 2'h3);
  assign zeroA  = (cmpA_q == 10'h000);
  assign matchA = (cnt_q == cmpA_q);
  assign matchP = (cnt_q[9:7] == ctrl0_q.cmpP) && (cnt_q[6:0] == 7'h00);
  // Period and duty lengths in counter clocks; a P value of 0 codes 1024
  assign perCnt = ctrl1_q.swap ? {1'b0, cmpA_q} :
                  {(ctrl0_q.cmpP == 3'h0), ctrl0_q.cmpP, 7'h00};
  assign dutyCnt = ctrl1_q.swap ? {(ctrl0_q.cmpP == 3'h0), ctrl0_q.cmpP, 7'h00} :
                   {1'b0, cmpA_q};

  // Last count of a PWM period; the counter never reaches the period value itself
  assign perHit = (11'(cnt_q) + 11'h1 == perCnt);

  // Clear cause per mode; capture mode is not handled here
  always_comb begin
    clrCnt = 1'b0;
    setA   = 1'b0;
    setP   = 1'b0;
    if (isPwm) begin
      // Period register clears the counter; clear select is ignored
      clrCnt = perHit || (cnt_q == `STMCP_CNT_MAX);
      // The period register's match is its clearing count, else it would never fire
      setA   = ctrl1_q.swap ? perHit : matchA;
      setP   = ctrl1_q.swap ? matchP : perHit;
    end else if (ctrl1_q.mode == STMCP_CMP || ctrl1_q.mode == STMCP_TMR) begin
      setA = matchA && !zeroA;
      if (ctrl1_q.clrSel) begin
        clrCnt = (matchA && !zeroA) || (cnt_q == `STMCP_CNT_MAX);
      end else begin
        setP   = matchP && (ctrl0_q.cmpP != 3'h0);
        clrCnt = setP || (cnt_q == `STMCP_CNT_MAX);
      end
    end
  end

  // Counter runs on each counter clock while on and not paused
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q    <= 10'h000;
      onPrev_q <= 1'b0;
    end else begin
      onPrev_q <= ctrl0_q.timerOn;
      if (onRise) cnt_q <= 10'h000;
      else if (ctrl0_q.timerOn && !ctrl0_q.pause && tick)
        cnt_q <= clrCnt ? 10'h000 : cnt_q + 10'h001;
    end
  end

  logic evA, evP;
  assign evA = ctrl0_q.timerOn && !ctrl0_q.pause && tick && !onRise && setA;
  assign evP = ctrl0_q.timerOn && !ctrl0_q.pause && tick && !onRise && setP;

  // ----------------------------------------------------------------
  // Match flags, sticky, write one to clear
  // ----------------------------------------------------------------
  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flagA_q <= 1'b0;
      flagP_q <= 1'b0;
    end else begin
      flagA_q <= evA || (flagA_q && !(wrFlags && wData_q[`STMCP_FL_A]));
      flagP_q <= evP || (flagP_q && !(wrFlags && wData_q[`STMCP_FL_P]));
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  logic pwmAct;
  assign pwmAct = (dutyCnt >= perCnt) || (11'(cnt_q) < dutyCnt);

  // Compare pin level is held state; PWM level is recomputed each cycle
  always_ff @(posedge ref_clk) begin
    if (rst) pin_q <= 1'b0;
    else if (onRise) pin_q <= ctrl1_q.initLvl;
    else if (evA && ctrl1_q.mode == STMCP_CMP) begin
      unique case (ctrl1_q.func)
        2'h0: pin_q <= pin_q;
        2'h1: pin_q <= 1'b0;
        2'h2: pin_q <= 1'b1;
        2'h3: pin_q <= !pin_q;
      endcase
    end
  end

  logic pinNext, enNext;
  always_comb begin
    pinNext = pin_q ^ ctrl1_q.invert;
    enNext  = (ctrl1_q.mode == STMCP_CMP);
    if (isPwm) begin
      enNext = 1'b1;
      unique case (ctrl1_q.func)
        2'h0: pinNext = !ctrl1_q.initLvl;
        2'h1: pinNext = ctrl1_q.initLvl;
        default: pinNext = ctrl1_q.initLvl ? pwmAct : !pwmAct;
      endcase
      pinNext = pinNext ^ ctrl1_q.invert;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timerOut   <= 1'b0;
      timerOutEn <= 1'b0;
    end else begin
      timerOut   <= pinNext;
      timerOutEn <= enNext;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cntHigh;
    @(posedge ref_clk) disable iff (rst) s_axi_rvalid && $past(s_axi_araddr) == `STMCP_OFF_CNTH
      |-> s_axi_rdata[7:2] == 6'h00;
  endproperty
  a_cntHigh: assert property (p_cntHigh) else $error("counter high byte upper bits set");

  property p_onClear;
    @(posedge ref_clk) disable iff (rst) onRise |=> cnt_q == 10'h000;
  endproperty
  a_onClear: assert property (p_onClear) else $error("counter not cleared on start");

  property p_offHold;
    @(posedge ref_clk) disable iff (rst) !ctrl0_q.timerOn && !onRise ##1 !ctrl0_q.timerOn
      |-> $stable(cnt_q);
  endproperty
  a_offHold: assert property (p_offHold) else $error("counter moved while off");

  property p_noPclrSel;
    @(posedge ref_clk) disable iff (rst) !isPwm && ctrl1_q.clrSel |-> !evP;
  endproperty
  a_noPclrSel: assert property (p_noPclrSel) else $error("P flag event with clear select");

  property p_zeroA;
    @(posedge ref_clk) disable iff (rst) !isPwm && zeroA |-> !evA;
  endproperty
  a_zeroA: assert property (p_zeroA) else $error("A flag with compare A zero");

  property p_flagSticky;
    @(posedge ref_clk) disable iff (rst) flagA_q && !wrFlags |=> flagA_q;
  endproperty
  a_flagSticky: assert property (p_flagSticky) else $error("A flag dropped");

  property p_setWins;
    @(posedge ref_clk) disable iff (rst) evP |=> flagP_q;
  endproperty
  a_setWins: assert property (p_setWins) else $error("P flag event lost");

  property p_initLvl;
    @(posedge ref_clk) disable iff (rst) onRise |=> pin_q == $past(ctrl1_q.initLvl);
  endproperty
  a_initLvl: assert property (p_initLvl) else $error("pin not at initial level");

  property p_tmrNoDrive;
    @(posedge ref_clk) disable iff (rst) ctrl1_q.mode == STMCP_TMR ##1 ctrl1_q.mode == STMCP_TMR
      |-> !timerOutEn;
  endproperty
  a_tmrNoDrive: assert property (p_tmrNoDrive) else $error("pin driven in timer mode");

endmodule : stmcp_timer

// ### stmcp_tb.sv
`timescale 1ns/100ps
`include "stmcp_map.svh"
module tb;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdat;
    logic [7:0]  exp;
    logic [1:0]  resp;
  } stmcp_row_t;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, timerOut, timerOutEn;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          mismatches = 0;
  int          compares = 0;
  logic [31:0] d;
  logic [1:0]  rs;
  stmcp_row_t  rows [9];

  stmcp_timer i_dut (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timerOut(timerOut), .timerOutEn(timerOutEn)
  );

  // 125 MHz reference clock
  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // Address and data offered together; each dropped once its own ready is seen
  task automatic axiWrite(input logic [11:0] ad, input logic [7:0] dt, output logic [1:0] r);
    logic aw, w;
    @(posedge ref_clk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= ad;
    wdata <= {24'h0, dt};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge ref_clk);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    dt = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : checkData

  task automatic checkResp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: response %h expected %h", $time, got, exp);
    end
  endtask : checkResp

  // Timer run: settle, then count high pin cycles over a window of win reference clocks
  task automatic runCase(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a,
                         input int win, input int expHigh, input logic [1:0] fl,
                         input logic en);
    int hi;
    logic [31:0] c0;
    hi = 0;
    axiWrite(`STMCP_OFF_CTRL0, {5'h00, p}, rs);
    axiWrite(`STMCP_OFF_CMPAL, a[7:0], rs);
    axiWrite(`STMCP_OFF_CMPAH, {6'h00, a[9:8]}, rs);
    axiWrite(`STMCP_OFF_CTRL1, c1, rs);
    axiWrite(`STMCP_OFF_FLAGS, 8'h03, rs);
    axiWrite(`STMCP_OFF_CTRL0, {5'h01, p}, rs);
    repeat (600) @(posedge ref_clk);
    repeat (win) begin
      @(posedge ref_clk);
      hi += (timerOut === 1'b1) ? 1 : 0;
    end
    checkData(hi, expHigh);
    checkData({31'h0, timerOutEn}, {31'h0, en});
    axiWrite(`STMCP_OFF_CTRL0, {5'h00, p}, rs);
    axiRead(`STMCP_OFF_FLAGS, d, rs);
    checkData(d & 32'h3, {30'h0, fl});
    axiRead(`STMCP_OFF_CNTL, c0, rs);
    repeat (20) @(posedge ref_clk);
    axiRead(`STMCP_OFF_CNTL, d, rs);
    checkData(d, c0);
  endtask : runCase

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Rows: write flag, address, write data, read-back, response
  initial begin
    rows[0] = '{1'b0, `STMCP_OFF_CNTL, 8'h00, 8'h00, 2'h0};
    rows[1] = '{1'b0, `STMCP_OFF_CNTH, 8'h00, 8'h00, 2'h0};
    rows[2] = '{1'b0, `STMCP_OFF_CMPAL, 8'h00, 8'h00, 2'h0};
    rows[3] = '{1'b0, `STMCP_OFF_CMPAH, 8'h00, 8'h00, 2'h0};
    rows[4] = '{1'b1, `STMCP_OFF_CMPAL, 8'hA5, 8'hA5, 2'h0};
    rows[5] = '{1'b1, `STMCP_OFF_CMPAH, 8'hFF, 8'h03, 2'h0};
    rows[6] = '{1'b1, `STMCP_OFF_CNTH, 8'hFF, 8'h00, 2'h0};
    rows[7] = '{1'b1, `STMCP_OFF_CTRL1, 8'h5A, 8'h5A, 2'h0};
    rows[8] = '{1'b1, 12'h01C, 8'h77, 8'h00, 2'h2};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axiWrite(rows[i].addr, rows[i].wdat, rs);
        checkResp(rs, rows[i].resp);
      end
      axiRead(rows[i].addr, d, rs);
      checkData(d, {24'h0, rows[i].exp});
      checkResp(rs, rows[i].resp);
    end
    runCase(8'h21, 3'h1, 10'h005, 512, 512, 2'b01, 1'b1);
    runCase(8'h18, 3'h1, 10'h005, 512, 0, 2'b11, 1'b1);
    runCase(8'hC1, 3'h1, 10'h005, 0, 0, 2'b01, 1'b0);
    runCase(8'h20, 3'h0, 10'h000, 4400, 0, 2'b00, 1'b1);
    runCase(8'hA8, 3'h1, 10'h020, 1024, 256, 2'b11, 1'b1);
    runCase(8'hAA, 3'h1, 10'h0C8, 800, 512, 2'b11, 1'b1);
    runCase(8'hA9, 3'h1, 10'h3FF, 512, 512, 2'b10, 1'b1);
    runCase(8'h98, 3'h1, 10'h020, 512, 512, 2'b11, 1'b1);
    runCase(8'h88, 3'h1, 10'h020, 512, 0, 2'b11, 1'b1);
    runCase(8'h8C, 3'h1, 10'h020, 512, 512, 2'b11, 1'b1);
    end_of_test();
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    end_of_test();
  end
endmodule : tb
